// ### hw/sync_level.v
// Purpose: two-flop synchroniser for a multi-bit level or toggle
// Assumes: each bit changes independently or is held stable
// Notes: first stage read only by second stage
`timescale 1ns/100ps
module sync_level #(
  parameter WIDTH = 1
) (
  input wire clk,
  input wire arst_n,
  input wire [WIDTH-1:0] din,
  output wire [WIDTH-1:0] dout
);
  reg [WIDTH-1:0] stage1_reg;
  reg [WIDTH-1:0] stage2_reg;

  // plain double flop, reset to zero
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stage1_reg <= {WIDTH{1'b0}};
      stage2_reg <= {WIDTH{1'b0}};
    end else begin
      stage1_reg <= din;
      stage2_reg <= stage1_reg;
    end
  end

  assign dout = stage2_reg;
endmodule // sync_level

// ### hw/watchdog_timer.v
// Purpose: watchdog timer with fuse-selected safety levels
// Assumes: oscClk is a free-running ~1 MHz on-chip oscillator
// Notes: porRst_n marks power-on; arst_n is any chip reset
`timescale 1ns/100ps
`include "watchdog_defines.vh"
module watchdog_timer #(
  parameter CNT_W = 22
) (
  input wire clk,
  input wire arst_n,
  input wire porRst_n,
  input wire oscClk,
  input wire compatFuse,
  input wire alwaysOnFuse,
  input wire restartInstr,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  output wire wdResetPulse,
  output wire irq
);
  localparam LVL0 = 2'h0;
  localparam LVL1 = 2'h1;
  localparam LVL2 = 2'h2;

  reg [1:0] level_reg;
  reg [1:0] fuseSync1_reg;
  reg [1:0] fuseSync2_reg;
  reg levelValid_reg;
  reg enable_reg;
  reg enable_next;
  reg unlock_reg;
  reg unlock_next;
  reg [2:0] unlockCnt_reg;
  reg [2:0] period_reg;
  reg [2:0] period_next;
  reg restartTgl_reg;
  reg restartPend_reg;
  reg expireSeen_reg;
  reg resetPulse_reg;
  reg toFlag_reg;
  reg [1:0] status_reg;
  reg [1:0] mask_reg;
  reg ack_reg;
  reg reject;
  wire [1:0] levelNow;
  wire ctrlWr;
  wire wrUnlock;
  wire wrEnable;
  wire [2:0] wrPeriod;
  wire expireTglSync;
  wire expireTgl;
  wire [4:0] oscCtrl;
  wire restartAck;
  wire restartBusy;
  wire oscRunEn;
  wire oscRestart;
  wire [2:0] oscPeriod;
  wire oscRst_n;
  wire expireEvt;
  wire [1:0] statusSet;
  wire [7:0] ctrlRead;

  // fuses pass two flops with no reset, so the level is already
  // settled when chip reset releases and can be latched at once
  always @(posedge clk) begin
    fuseSync1_reg <= {alwaysOnFuse, compatFuse};
    fuseSync2_reg <= fuseSync1_reg;
  end

  // level decode: always-on dominates
  assign levelNow = fuseSync2_reg[1] ? LVL2 : (fuseSync2_reg[0] ? LVL0 : LVL1);

  // two-cycle avalon slave, no wait states beyond the first
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
  assign ctrlWr = avs_write & ack_reg & (avs_address == `WD_CONTROL_OFFSET) & avs_byteenable[0];
  assign wrUnlock = avs_writedata[`WD_UNLOCK_BIT];
  assign wrEnable = avs_writedata[`WD_ENABLE_BIT];
  assign wrPeriod = avs_writedata[`WD_PERIOD_MSB:`WD_PERIOD_LSB];

  // ack alternates, so every access takes two cycles and never stalls longer
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (avs_read | avs_write) & ~ack_reg;
    end
  end

  // control write policy by safety level; an unlock write opens a
  // window of four edges, and in levels 1 and 2 the completing write closes it early
  // so that one unlock buys exactly one change
  always @* begin
    enable_next = enable_reg;
    unlock_next = unlock_reg;
    period_next = period_reg;
    reject = 1'b0;
    if (unlockCnt_reg == 3'h1) begin
      unlock_next = 1'b0;
    end
    if (ctrlWr) begin
      if (wrUnlock && wrEnable) begin
        unlock_next = 1'b1;
        enable_next = 1'b1;
      end else if (wrEnable) begin
        enable_next = 1'b1;
      end else if (level_reg == LVL2) begin
        enable_next = 1'b1;
      end else if (unlock_reg) begin
        enable_next = 1'b0;
      end else begin
        reject = enable_reg;
      end
      if (level_reg == LVL0) begin
        period_next = wrPeriod;
      end else if (unlock_reg && !wrUnlock) begin
        period_next = wrPeriod;
        unlock_next = 1'b0;
      end else if (wrPeriod != period_reg && !(wrUnlock && wrEnable)) begin
        reject = 1'b1;
      end
    end
  end

  // control state; level and initial enable caught after reset release
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      levelValid_reg <= 1'b0;
      level_reg <= LVL1;
      enable_reg <= 1'b0;
      unlock_reg <= 1'b0;
      unlockCnt_reg <= 3'h0;
      period_reg <= `WD_PERIOD_RESET;
    end else if (!levelValid_reg) begin
      levelValid_reg <= 1'b1;
      level_reg <= levelNow;
      enable_reg <= (levelNow == LVL2);
    end else begin
      enable_reg <= enable_next;
      unlock_reg <= unlock_next;
      period_reg <= period_next;
      if (ctrlWr && wrUnlock && wrEnable) begin
        unlockCnt_reg <= `WD_UNLOCK_CYCLES;
      end else if (unlockCnt_reg != 3'h0) begin
        unlockCnt_reg <= unlockCnt_reg - 3'h1;
      end
    end
  end

  // restart instruction becomes a toggle for the oscillator side; a restart
  // arriving while one is still in flight waits, so none cancels another
  assign restartBusy = restartTgl_reg ^ restartAck;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      restartTgl_reg <= 1'b0;
      restartPend_reg <= 1'b0;
    end else if ((restartInstr || restartPend_reg) && !restartBusy) begin
      restartTgl_reg <= ~restartTgl_reg;
      restartPend_reg <= 1'b0;
    end else if (restartInstr) begin
      restartPend_reg <= 1'b1;
    end
  end

  // oscillator copy of the toggle returns as the acknowledge
  sync_level #(.WIDTH(1)) u_ackSync (
    .clk(clk),
    .arst_n(arst_n),
    .din(oscRestart),
    .dout(restartAck)
  );

  // oscillator-domain reset: async assert, release synchronised
  sync_level #(.WIDTH(1)) u_oscRstSync (
    .clk(oscClk),
    .arst_n(arst_n),
    .din(1'b1),
    .dout(oscRst_n)
  );

  // enable, restart toggle and period cross as levels; a period change
  // may show a mixed code for one oscillator cycle, so change it with care
  sync_level #(.WIDTH(5)) u_ctrlSync (
    .clk(oscClk),
    .arst_n(arst_n),
    .din({enable_reg & levelValid_reg, restartTgl_reg, period_reg}),
    .dout(oscCtrl)
  );
  assign oscRunEn = oscCtrl[4];
  assign oscRestart = oscCtrl[3];
  assign oscPeriod = oscCtrl[2:0];

  // time-out counter on the oscillator clock
  wdt_counter #(.CNT_W(CNT_W)) u_counter (
    .oscClk(oscClk),
    .oscRst_n(oscRst_n),
    .runEn(oscRunEn),
    .periodSel(oscPeriod),
    .restartTgl(oscRestart),
    .expireTgl(expireTgl)
  );

  // expiry toggle back to the system clock
  sync_level #(.WIDTH(1)) u_expSync (
    .clk(clk),
    .arst_n(arst_n),
    .din(expireTgl),
    .dout(expireTglSync)
  );

  // a stale toggle arriving after a disable is dropped here
  assign expireEvt = (expireTglSync ^ expireSeen_reg) & enable_reg;

  // single-cycle chip reset pulse on expiry
  // registered so the reset request is exactly one clock long
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      expireSeen_reg <= 1'b0;
      resetPulse_reg <= 1'b0;
    end else begin
      expireSeen_reg <= expireTglSync;
      resetPulse_reg <= expireEvt;
    end
  end
  assign wdResetPulse = resetPulse_reg;

  // reset-source flag survives chip reset, cleared by power-on
  always @(posedge clk or negedge porRst_n) begin
    if (!porRst_n) begin
      toFlag_reg <= 1'b0;
    end else if (resetPulse_reg) begin
      toFlag_reg <= 1'b1;
    end else if (avs_write && ack_reg && avs_address == `WD_RESETFLAG_OFFSET && avs_byteenable[0] &&
                 !avs_writedata[`WD_TOFLAG_BIT]) begin
      toFlag_reg <= 1'b0;
    end
  end

  // sticky interrupt status, set beats write-one-to-clear
  // so an event in the clearing cycle is never lost
  assign statusSet = {reject, expireEvt};
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      status_reg <= 2'h0;
      mask_reg <= `WD_MASK_RESET;
    end else begin
      if (avs_write && ack_reg && avs_address == `WD_STATUS_OFFSET && avs_byteenable[0]) begin
        status_reg <= (status_reg & ~avs_writedata[1:0]) | statusSet;
      end else begin
        status_reg <= status_reg | statusSet;
      end
      if (avs_write && ack_reg && avs_address == `WD_MASK_OFFSET && avs_byteenable[0]) begin
        mask_reg <= avs_writedata[1:0];
      end
    end
  end
  assign irq = |(status_reg & mask_reg);

  // reserved bits zero; level 2 reads enable as one
  assign ctrlRead = {3'h0, unlock_reg, enable_reg | (level_reg == LVL2), period_reg};

  // read data registered at the first edge of a read, while waitrequest is high; unmapped reads zero
  // captured when the request is taken, standing while waitrequest is low
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      avs_readdata <= 32'h0;
    end else if (avs_read && !ack_reg) begin
      case (avs_address)
        `WD_CONTROL_OFFSET: avs_readdata <= {24'h0, ctrlRead};
        `WD_RESETFLAG_OFFSET: avs_readdata <= {31'h0, toFlag_reg};
        `WD_STATUS_OFFSET: avs_readdata <= {30'h0, status_reg};
        `WD_MASK_OFFSET: avs_readdata <= {30'h0, mask_reg};
        default: avs_readdata <= 32'h0;
      endcase
    end
  end
endmodule // watchdog_timer

// ### hw/wdt_counter.v
// Purpose: watchdog time-out counter on the oscillator clock
// Assumes: controls arrive already synchronised to oscClk
// Notes: expiry is reported as a toggle for safe crossing
`timescale 1ns/100ps
`include "watchdog_defines.vh"
module wdt_counter #(
  parameter CNT_W = 22
) (
  input wire oscClk,
  input wire oscRst_n,
  input wire runEn,
  input wire [2:0] periodSel,
  input wire restartTgl,
  output wire expireTgl
);
  reg [CNT_W-1:0] count_reg;
  reg restartSeen_reg;
  reg expireTgl_reg;
  wire [CNT_W-1:0] limit;
  wire restartHit;

  // terminal count is 2^(14+sel)-1
  assign limit = ({{(CNT_W-1){1'b0}}, 1'b1} << (`WD_BASE_LOG2 + periodSel)) - {{(CNT_W-1){1'b0}}, 1'b1};
  assign restartHit = restartTgl ^ restartSeen_reg;

  // count clears on restart, on disable and on chip reset
  always @(posedge oscClk or negedge oscRst_n) begin
    if (!oscRst_n) begin
      count_reg <= {CNT_W{1'b0}};
      restartSeen_reg <= 1'b0;
      expireTgl_reg <= 1'b0;
    end else begin
      restartSeen_reg <= restartTgl;
      if (!runEn || restartHit) begin
        count_reg <= {CNT_W{1'b0}};
      end else if (count_reg >= limit) begin
        count_reg <= {CNT_W{1'b0}};
        expireTgl_reg <= ~expireTgl_reg;
      end else begin
        count_reg <= count_reg + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  assign expireTgl = expireTgl_reg;
endmodule // wdt_counter

// ### inc/watchdog_defines.vh
// Purpose: constants for the watchdog timer block
// Assumes: 32-bit Avalon-MM word registers, byte addresses
// Notes: fuse inputs are active high meaning programmed
`ifndef WATCHDOG_DEFINES_VH
`define WATCHDOG_DEFINES_VH
// register byte offsets
`define WD_CONTROL_OFFSET 4'h0
`define WD_RESETFLAG_OFFSET 4'h4
`define WD_STATUS_OFFSET 4'h8
`define WD_MASK_OFFSET 4'hc
// control field positions
`define WD_UNLOCK_BIT 4
`define WD_ENABLE_BIT 3
`define WD_PERIOD_MSB 2
`define WD_PERIOD_LSB 0
// reset flag position
`define WD_TOFLAG_BIT 0
// reset values
`define WD_PERIOD_RESET 3'h0
`define WD_MASK_RESET 2'h0
// unlock window length in system clock cycles
`define WD_UNLOCK_CYCLES 3'h4
// shortest period in oscillator cycles, as a power of two
`define WD_BASE_LOG2 14
// interrupt status bits
`define WD_IRQ_TIMEOUT 0
`define WD_IRQ_REJECT 1
`endif

// ### testbench/tb.sv
// Purpose: self-checking bench for the watchdog timer
// Assumes: a fast oscillator stands in for 1 MHz to keep runs short
// Notes: safety level changes only across a chip reset
`timescale 1ns/100ps
module tb;
  reg clk = 0, arst_n = 0, porRst_n = 0, oscClk = 0, compatFuse = 0, alwaysOnFuse = 0, restartInstr = 0;
  reg rd = 0, wr = 0;
  reg [3:0] addr = 4'h0;
  reg [31:0] wdata = 32'h0, rv, rnd;
  reg [7:0] v, cur;
  wire [31:0] rdata;
  wire waitReq, pulse, irq;
  integer n_fail = 0, samples_checked = 0, seed = 32'hccc0, i, cyc, pulses = 0;
  // clocks with unrelated phase; oscillator period 2.2 ns
  always #2 clk = ~clk;
  always #1.1 oscClk = ~oscClk;
  always @(posedge clk) if (pulse === 1'b1) pulses = pulses + 1;
  watchdog_timer dut (.clk(clk), .arst_n(arst_n), .porRst_n(porRst_n), .oscClk(oscClk), .compatFuse(compatFuse),
    .alwaysOnFuse(alwaysOnFuse), .restartInstr(restartInstr), .avs_address(addr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wdata), .avs_byteenable(4'hf), .avs_readdata(rdata), .avs_waitrequest(waitReq),
    .wdResetPulse(pulse), .irq(irq));
  task end_of_test;
    begin
      $display("compares %0d, mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // one access; waitrequest and read data taken at the rising edge
  task bus(input w, input [3:0] a, input [7:0] d);
    integer k;
    begin
      @(posedge clk);
      rd <= !w;
      wr <= w;
      addr <= a;
      wdata <= {24'h0, d};
      k = 0;
      @(posedge clk);
      while (waitReq !== 1'b0 && k < 20) begin
        @(posedge clk);
        k = k + 1;
      end
      if (k >= 20) begin
        n_fail = n_fail + 1;
        end_of_test;
      end
      rv = rdata;
      rd <= 0;
      wr <= 0;
    end
  endtask
  task rst(input c, input a);
    begin
      arst_n <= 0;
      compatFuse <= c;
      alwaysOnFuse <= a;
      repeat (16) @(posedge clk);
      arst_n <= 1;
      porRst_n <= 1;
      repeat (2) @(posedge clk);
    end
  endtask
  // level 0 without an unlock keeps enable once set, period taken as written
  function [7:0] lvl0(input [7:0] prev, input [7:0] w);
    lvl0 = {4'h0, prev[3] | w[3], w[2:0]};
  endfunction
  initial begin
    rst(1, 0);
    bus(0, 4'h0, 0); chk(rv, 0);
    cur = 8'h00;
    for (i = 0; i < 8; i = i + 1) begin
      rnd = $random(seed);
      v = {4'h0, rnd[3], i[2:0]};
      bus(1, 4'h0, v); bus(0, 4'h0, 0); cur = lvl0(cur, v); chk(rv, {24'h0, cur});
    end
    bus(1, 4'h0, 8'hef); bus(0, 4'h0, 0); chk(rv, 32'h0f);
    bus(1, 4'h0, 8'h00); bus(0, 4'h0, 0); chk(rv, 32'h08);
    bus(1, 4'h0, 8'h18); bus(1, 4'h0, 8'h02); bus(0, 4'h0, 0); chk(rv, 32'h02);
    bus(0, 4'h6, 0); chk(rv, 0);
    $display("level 0 test done");
    rst(0, 0);
    bus(0, 4'h0, 0); chk(rv, 0);
    bus(1, 4'h0, 8'h0b); bus(0, 4'h0, 0); chk(rv, 32'h08);
    bus(1, 4'h0, 8'h00); bus(0, 4'h0, 0); chk(rv, 32'h08);
    bus(0, 4'h8, 0); chk(rv & 32'h2, 32'h2);
    bus(1, 4'h0, 8'h18); repeat (6) @(posedge clk); bus(0, 4'h0, 0); chk(rv, 32'h08);
    bus(1, 4'h0, 8'h00); bus(0, 4'h0, 0); chk(rv, 32'h08);
    bus(1, 4'h0, 8'h18); bus(1, 4'h0, 8'h03); bus(0, 4'h0, 0); chk(rv, 32'h03);
    bus(1, 4'h0, 8'h18); bus(1, 4'h0, 8'h08); bus(1, 4'h8, 8'h03); bus(1, 4'hc, 8'h01);
    // restarts spaced well inside the shortest period
    for (i = 0; i < 5; i = i + 1) begin
      rnd = $random(seed);
      repeat (2000 + rnd[9:0]) @(posedge clk);
      restartInstr <= 1;
      @(posedge clk);
      restartInstr <= 0;
    end
    chk(pulses, 0);
    cyc = 0;
    while (pulses == 0 && cyc < 12000) begin
      @(posedge clk);
      cyc = cyc + 1;
    end
    if (pulses == 0) begin
      n_fail = n_fail + 1;
      end_of_test;
    end
    chk({31'h0, cyc > 16384 * 22 / 40 - 50 && cyc < 16384 * 22 / 40 + 150}, 1);
    repeat (4) @(posedge clk);
    @(negedge clk); chk(pulses, 1);
    chk({31'h0, irq}, 1);
    bus(0, 4'h4, 0); chk(rv, 1);
    bus(1, 4'hc, 8'h00); @(negedge clk); chk({31'h0, irq}, 0);
    bus(1, 4'hc, 8'h01); @(negedge clk); chk({31'h0, irq}, 1);
    bus(1, 4'h8, 8'h01); @(negedge clk); chk({31'h0, irq}, 0);
    $display("level 1 test done");
    rst(0, 1);
    bus(0, 4'h4, 0); chk(rv, 1);
    bus(1, 4'h4, 8'h00); bus(0, 4'h4, 0); chk(rv, 0);
    bus(0, 4'h0, 0); chk(rv, 32'h08);
    bus(1, 4'h0, 8'h18); bus(1, 4'h0, 8'h02); bus(0, 4'h0, 0); chk(rv, 32'h0a);
    bus(1, 4'h0, 8'h01); bus(0, 4'h0, 0); chk(rv, 32'h0a);
    $display("level 2 test done");
    end_of_test;
  end
endmodule // tb

// ### testbench/watchdog_checker.sv
// Purpose: bus and pulse properties of the watchdog timer
// Assumes: one access at a time, request dropped after each answer
// Notes: sees only the top module's ports
`timescale 1ns/100ps
module watchdog_checker #(
  parameter CNT_W = 22
) (
  input wire clk,
  input wire arst_n,
  input wire porRst_n,
  input wire oscClk,
  input wire compatFuse,
  input wire alwaysOnFuse,
  input wire restartInstr,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire wdResetPulse,
  input wire irq
);
  // request and read completion, plain nets only
  wire req = avs_read || avs_write;
  wire rdDone = avs_read && !avs_waitrequest;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  wait_first_a: assert property (req && !$past(req) |-> avs_waitrequest) else $error("no stall on new request");
  wait_bound_a: assert property (req && avs_waitrequest |=> !avs_waitrequest) else $error("answer late");
  reserved_zero_a: assert property (rdDone && avs_address == 4'h0 |-> avs_readdata[31:5] == 27'h0)
    else $error("reserved control bits set");
  unmapped_zero_a: assert property (rdDone && avs_address[1:0] != 2'h0 |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  always_on_a: assert property (rdDone && avs_address == 4'h0 && alwaysOnFuse |-> avs_readdata[3])
    else $error("enable reads zero in level 2");
  pulse_single_a: assert property (wdResetPulse |=> !wdResetPulse [*8])
    else $error("reset pulse too long");
  irq_sticky_a: assert property (irq && !avs_write |=> irq) else $error("irq dropped without a write");
  rdata_hold_a: assert property (!avs_read |=> $stable(avs_readdata)) else $error("read data moved");
endmodule // watchdog_checker

bind watchdog_timer watchdog_checker #(.CNT_W(CNT_W)) chk (.clk(clk), .arst_n(arst_n), .porRst_n(porRst_n),
  .oscClk(oscClk), .compatFuse(compatFuse), .alwaysOnFuse(alwaysOnFuse), .restartInstr(restartInstr),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .wdResetPulse(wdResetPulse), .irq(irq));
